// ==== rtl/psmc_phase_gen.sv ====
// machine cycle phase generator with optional divide-by-eight prescaler
`timescale 1ns/1ps
`default_nettype none
`include "psmc_regs.svh"

module psmc_phase_gen #(
  parameter int DIV    = `PSMC_SLOW_DIV,
  parameter int PHASES = `PSMC_MC_PHASES,
  parameter int SAMPLE = `PSMC_S3P1_PHASE
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // control
  input  wire logic                        run,
  input  wire logic                        slow,
  // timing out
  output logic                             tick,
  output logic                             sample_pulse,
  output logic [$clog2(PHASES)-1:0]        phase
);
  localparam int DW = $clog2(DIV);
  localparam int PW = $clog2(PHASES);

  generate
    // the prescaler wraps by overflow, so only powers of two divide correctly
    if (DIV < 2 || (DIV & (DIV - 1)) != 0 || PHASES < 2 || SAMPLE >= PHASES) begin : g_bad
      $error("psmc_phase_gen: unsupported divider or phase setting");
    end
  endgenerate

  logic [DW-1:0] div_cnt;
  logic [DW-1:0] next_div_cnt;
  logic [PW-1:0] next_phase;

  // a stopped oscillator produces no tick at all
  assign tick         = run & (~slow | (div_cnt == DW'(DIV - 1)));
  assign sample_pulse = tick & (phase == PW'(SAMPLE));

  always_comb begin
    next_div_cnt = div_cnt;
    next_phase   = phase;
    if (!run || !slow) begin
      next_div_cnt = '0;
    end else begin
      next_div_cnt = div_cnt + 1'b1;
    end
    if (tick) begin
      next_phase = (phase == PW'(PHASES - 1)) ? '0 : phase + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      phase   <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      phase   <= next_phase;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/psmc_top.sv ====
// power saving mode control: sleep, halt and slow-down with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "psmc_regs.svh"

module psmc_top
  import psmc_pkg::*;
#(
  parameter int DIV    = `PSMC_SLOW_DIV,
  parameter int PHASES = `PSMC_MC_PHASES
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // pins and events
  input  wire logic                    save_enable_wdt_start_pin,
  input  wire logic                    wake_irq,
  // clock gating and pin control
  output psmc_clk_t                    clk_ctl,
  output psmc_strobe_t                 strobe_ctl,
  output logic                         wdt_run,
  output logic                         slow_mode,
  output logic [$clog2(PHASES)-1:0]    machine_phase
);

  generate
    if (DIV != `PSMC_SLOW_DIV) begin : g_bad_div
      $error("psmc_top: slow-down divider must be eight");
    end
  endgenerate

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic acc;
  logic wr;
  logic hit_pctrl;
  logic hit_status;
  logic hit_wdtctl;
  logic mapped;

  // zero wait states: every access completes in its first access cycle
  assign pready     = 1'b1;
  assign acc        = psel & penable;
  assign wr         = acc & pwrite;
  assign hit_pctrl  = (paddr == `PSMC_OFF_PCTRL);
  assign hit_status = (paddr == `PSMC_OFF_STATUS);
  assign hit_wdtctl = (paddr == `PSMC_OFF_WDTCTL);
  assign mapped     = hit_pctrl | hit_status | hit_wdtctl;
  assign pslverr    = acc & ~mapped;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  psmc_mode_t mode;
  psmc_mode_t next_mode;
  logic       slow;
  logic       next_slow;
  logic       gf0;
  logic       next_gf0;
  logic       gf1;
  logic       next_gf1;
  logic       sleep_armed;
  logic       next_sleep_armed;
  logic       halt_armed;
  logic       next_halt_armed;
  logic       pin_level;
  logic       next_pin_level;
  logic       wdt_on;
  logic       next_wdt_on;
  logic       wdt_auto;
  logic       next_wdt_auto;
  logic       strap_done;
  logic       next_strap_done;

  logic       tick;
  logic       sample_pulse;

  psmc_phase_gen #(
    .DIV    (DIV),
    .PHASES (PHASES),
    .SAMPLE (`PSMC_S3P1_PHASE)
  ) u_phase (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (mode != PSMC_HALT),
    .slow         (slow),
    .tick         (tick),
    .sample_pulse (sample_pulse),
    .phase        (machine_phase)
  );

  // write fields of the power control register
  logic w_sarm;
  logic w_harm;
  logic w_sgo;
  logic w_hgo;
  logic modes_allowed;
  logic sleep_req;
  logic halt_req;

  assign w_sarm        = pwdata[`PSMC_BIT_SLEEP_ARM];
  assign w_harm        = pwdata[`PSMC_BIT_HALT_ARM];
  assign w_sgo         = pwdata[`PSMC_BIT_SLEEP_GO];
  assign w_hgo         = pwdata[`PSMC_BIT_HALT_GO];
  // pin high blocks every entry sequence
  assign modes_allowed = ~pin_level;

  // a go is honoured only when armed by the previous write and not set with its own arm
  assign sleep_req = wr & hit_pctrl & modes_allowed & sleep_armed
                   & w_sgo & ~w_sarm;
  assign halt_req  = wr & hit_pctrl & modes_allowed & halt_armed
                   & w_hgo & ~w_harm;

  // ------------------------------------------------------------------
  // mode and power control register
  // ------------------------------------------------------------------
  always_comb begin
    next_mode        = mode;
    next_slow        = slow;
    next_gf0         = gf0;
    next_gf1         = gf1;
    next_sleep_armed = sleep_armed;
    next_halt_armed  = halt_armed;
    case (mode)
      PSMC_RUN: begin
        // any write is an instruction; it consumes a pending arm
        if (wr) begin
          next_sleep_armed = 1'b0;
          next_halt_armed  = 1'b0;
        end
        if (wr && hit_pctrl) begin
          next_slow = pwdata[`PSMC_BIT_SLOW];
          next_gf0  = pwdata[`PSMC_BIT_GF0];
          next_gf1  = pwdata[`PSMC_BIT_GF1];
          // arm only when written alone, without its go bit
          if (modes_allowed && w_sarm && !w_sgo) begin
            next_sleep_armed = 1'b1;
          end
          if (modes_allowed && w_harm && !w_hgo) begin
            next_halt_armed = 1'b1;
          end
        end
        if (halt_req) begin
          next_mode = PSMC_HALT;
        end else if (sleep_req) begin
          next_mode = PSMC_SLEEP;
        end
      end
      PSMC_SLEEP: begin
        // cpu is frozen; only an enabled interrupt or a reset brings it back
        next_sleep_armed = 1'b0;
        next_halt_armed  = 1'b0;
        if (wake_irq) begin
          next_mode = PSMC_RUN;
        end
      end
      PSMC_HALT: begin
        // nothing but reset leaves halt
        next_sleep_armed = 1'b0;
        next_halt_armed  = 1'b0;
      end
      default: begin
        next_mode        = PSMC_RUN;
        next_sleep_armed = 1'b0;
        next_halt_armed  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode        <= PSMC_RUN;
      slow        <= 1'b0;
      gf0         <= 1'b0;
      gf1         <= 1'b0;
      sleep_armed <= 1'b0;
      halt_armed  <= 1'b0;
    end else begin
      mode        <= next_mode;
      slow        <= next_slow;
      gf0         <= next_gf0;
      gf1         <= next_gf1;
      sleep_armed <= next_sleep_armed;
      halt_armed  <= next_halt_armed;
    end
  end

  // ------------------------------------------------------------------
  // enable pin sampling and watchdog start
  // ------------------------------------------------------------------
  always_comb begin
    next_pin_level  = pin_level;
    next_wdt_on     = wdt_on;
    next_wdt_auto   = wdt_auto;
    next_strap_done = 1'b1;
    // level is only looked at once per machine cycle
    if (sample_pulse) begin
      next_pin_level = save_enable_wdt_start_pin;
    end
    // strap caught at the first edge after reset release, never later
    if (!strap_done && save_enable_wdt_start_pin) begin
      next_wdt_on   = 1'b1;
      next_wdt_auto = 1'b1;
    end
    // later pin levels do not touch the watchdog
    if (wr && hit_wdtctl && pwdata[`PSMC_BIT_WDT_START] && mode == PSMC_RUN) begin
      next_wdt_on = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level  <= `PSMC_PIN_RESET;
      wdt_on     <= 1'b0;
      wdt_auto   <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      pin_level  <= next_pin_level;
      wdt_on     <= next_wdt_on;
      wdt_auto   <= next_wdt_auto;
      strap_done <= next_strap_done;
    end
  end

  // ------------------------------------------------------------------
  // clock enables and pin control
  // ------------------------------------------------------------------
  logic         in_sleep;
  logic         in_halt;
  psmc_strobe_t next_strobe;

  assign in_sleep = (mode == PSMC_SLEEP);
  assign in_halt  = (mode == PSMC_HALT);

  // enables are per-tick pulses, so they come straight from the tick
  always_comb begin
    clk_ctl.osc_run   = ~in_halt;
    clk_ctl.cpu_en    = tick & ~in_sleep;
    clk_ctl.periph_en = tick;
    clk_ctl.wdt_en    = tick & ~in_sleep & wdt_on;
  end

  always_comb begin
    next_strobe.ale_high   = (next_mode == PSMC_SLEEP);
    next_strobe.program_store_strobe_high  = (next_mode == PSMC_SLEEP);
    next_strobe.ale_low    = (next_mode == PSMC_HALT);
    next_strobe.program_store_strobe_low   = (next_mode == PSMC_HALT);
    // ports freeze their latches; in sleep alternate functions keep their own clock
    next_strobe.port_hold  = (next_mode != PSMC_RUN);
    next_strobe.ram_retain = (next_mode == PSMC_HALT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_ctl <= '0;
    end else begin
      strobe_ctl <= next_strobe;
    end
  end

  assign wdt_run   = wdt_on;
  assign slow_mode = slow;

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == `PSMC_OFF_PCTRL) begin
        // arm and go bits always read back as zero
        next_prdata[`PSMC_BIT_SLOW] = slow;
        next_prdata[`PSMC_BIT_GF0]  = gf0;
        next_prdata[`PSMC_BIT_GF1]  = gf1;
      end else if (paddr == `PSMC_OFF_STATUS) begin
        next_prdata[`PSMC_BIT_ST_SLEEP] = in_sleep;
        next_prdata[`PSMC_BIT_ST_HALT]  = in_halt;
        next_prdata[`PSMC_BIT_ST_SLOW]  = slow;
        next_prdata[`PSMC_BIT_ST_PIN]   = pin_level;
        next_prdata[`PSMC_BIT_ST_WDT]   = wdt_on;
        next_prdata[`PSMC_BIT_ST_AUTO]  = wdt_auto;
        next_prdata[`PSMC_BIT_ST_SARM]  = sleep_armed;
        next_prdata[`PSMC_BIT_ST_HARM]  = halt_armed;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end else if (acc) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// ==== shared/psmc_pkg.sv ====
// types shared by the power saving control
package psmc_pkg;

  typedef enum logic [2:0] {
    PSMC_RUN   = 3'b001,
    PSMC_SLEEP = 3'b010,
    PSMC_HALT  = 3'b100
  } psmc_mode_t;

  typedef struct packed {
    logic osc_run;
    logic cpu_en;
    logic periph_en;
    logic wdt_en;
  } psmc_clk_t;

  typedef struct packed {
    logic ale_high;
    logic program_store_strobe_high;
    logic ale_low;
    logic program_store_strobe_low;
    logic port_hold;
    logic ram_retain;
  } psmc_strobe_t;

endpackage

// ==== shared/psmc_regs.svh ====
// register offsets, field positions, reset values and timing counts of the power saving control
// Functional notes
// - sleep keeps oscillator running, gates cpu clock so execution halts.
// - halt stops oscillator and all activity; ram contents kept.
// - slow-down divides whole chip clock by eight, everything stays functional.
// - all three modes are entered only by software through the power control register.
// - enable pin high makes arm/go sequences have no effect at all.
// - watchdog autostarts after reset release only if enable pin high during reset.
// - pin low allows every mode; watchdog then runs only when software starts it.
// - pin changes while running only gate mode entry, never the watchdog.
// - the enable pin is sampled in state 3 phase 1 of each machine cycle.
// - sleep and halt entry also need a correct arm-then-go write pair.
// - in sleep peripherals keep clock, only the watchdog clock stops.
// - in sleep the whole cpu state is preserved.
// - in sleep ports keep latched levels and active alternate outputs keep driving.
// - in sleep address latch and program store strobes are forced high.
// - in sleep ports still act as inputs for captures, counters and interrupts.
// - halt keeps ram contents at very low standby current.
// - sleep arm bit in one write, sleep go bit in the next; both together fail.
// - halt arm bit in one write, halt go bit in the next; both together fail.
// - arm and go bits clear themselves and always read as zero.
// - sleep ends on an enabled interrupt or a hardware reset.
`ifndef PSMC_REGS_SVH
`define PSMC_REGS_SVH

// apb byte offsets
`define PSMC_OFF_PCTRL      12'h000
`define PSMC_OFF_STATUS     12'h004
`define PSMC_OFF_WDTCTL     12'h008

// power_control_reg fields
`define PSMC_BIT_SLEEP_ARM  0
`define PSMC_BIT_HALT_ARM   1
`define PSMC_BIT_GF0        2
`define PSMC_BIT_GF1        3
`define PSMC_BIT_SLOW       4
`define PSMC_BIT_SLEEP_GO   5
`define PSMC_BIT_HALT_GO    6
`define PSMC_PCTRL_RESET    8'h00

// status fields
`define PSMC_BIT_ST_SLEEP   0
`define PSMC_BIT_ST_HALT    1
`define PSMC_BIT_ST_SLOW    2
`define PSMC_BIT_ST_PIN     3
`define PSMC_BIT_ST_WDT     4
`define PSMC_BIT_ST_AUTO    5
`define PSMC_BIT_ST_SARM    6
`define PSMC_BIT_ST_HARM    7

// watchdog control fields
`define PSMC_BIT_WDT_START  0

// timing
`define PSMC_SLOW_DIV       8
`define PSMC_MC_PHASES      12
`define PSMC_S3P1_PHASE     4
`define PSMC_PIN_RESET      1'b1

`endif

// ==== verif/psmc_monitor.sv ====
// assertion checker for the power saving mode control
`timescale 1ns/1ps
`default_nettype none
module psmc_monitor
  import psmc_pkg::*;
#(
  parameter int DIV    = 8,
  parameter int PHASES = 12
) (
  // clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // apb
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  // pins and controls
  input wire logic         wake_irq,
  input wire psmc_clk_t    clk_ctl,
  input wire psmc_strobe_t strobe_ctl,
  input wire logic         wdt_run,
  input wire logic         slow_mode
);
  logic sl;
  logic hl;
  logic wr0;
  assign sl  = strobe_ctl.ale_high;
  assign hl  = strobe_ctl.ram_retain;
  assign wr0 = psel && penable && pwrite && paddr == 12'h000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_slow_gap;
    (!clk_ctl.periph_en || !slow_mode)[*7];
  endsequence
  sequence s_slow_tick;
    clk_ctl.periph_en || !slow_mode || hl;
  endsequence
  property p_sleep_gate;
    sl |-> clk_ctl.osc_run && !clk_ctl.cpu_en && !strobe_ctl.ale_low;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gate");
  property p_halt_gate;
    hl |-> !clk_ctl.osc_run && !clk_ctl.periph_en && strobe_ctl.ale_low;
  endproperty
  a_halt_gate: assert property (p_halt_gate) else $error("halt gate");
  property p_halt_stay;
    hl |=> hl;
  endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("halt left");
  property p_sleep_go;
    $rose(sl) |-> $past(wr0 && pwdata[5] && !pwdata[0]);
  endproperty
  a_sleep_go: assert property (p_sleep_go) else $error("sleep without go");
  property p_halt_go;
    $rose(hl) |-> $past(wr0 && pwdata[6] && !pwdata[1]);
  endproperty
  a_halt_go: assert property (p_halt_go) else $error("halt without go");
  property p_wake;
    sl && wake_irq |=> !sl;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_wdt_tick;
    clk_ctl.wdt_en |-> wdt_run && !sl;
  endproperty
  a_wdt_tick: assert property (p_wdt_tick) else $error("watchdog tick");
  property p_wdt_keep;
    wdt_run |=> wdt_run;
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog stopped");
  property p_slow_div;
    slow_mode && $past(slow_mode) && clk_ctl.periph_en |=> s_slow_gap ##1 s_slow_tick;
  endproperty
  a_slow_div: assert property (p_slow_div) else $error("slow divide");
endmodule
bind psmc_top psmc_monitor #(.DIV(DIV), .PHASES(PHASES)) psmc_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .wake_irq(wake_irq), .clk_ctl(clk_ctl),
  .strobe_ctl(strobe_ctl), .wdt_run(wdt_run), .slow_mode(slow_mode));
`default_nettype wire

// ==== verif/psmc_supervisor.sv ====
// power-fail supervisor model driving the save enable pin
`timescale 1ns/1ps
`default_nettype none
module psmc_supervisor (
  // supply status
  input  wire logic power_fail,
  // pin
  output logic      save_enable_wdt_start_pin
);
  // open drain pulls low on a supply warning; released, the weak pull-up
  // wins, which keeps the modes blocked by default
  assign save_enable_wdt_start_pin = ~power_fail;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking testbench for the power saving mode control
`timescale 1ns/1ps
`default_nettype none
`include "psmc_regs.svh"
module testbench;
  import psmc_pkg::*;
  logic         pclk = 1'h0;
  logic         presetn = 1'h0;
  logic         psel = 1'h0;
  logic         penable = 1'h0;
  logic         pwrite = 1'h0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         power_fail = 1'h0;
  logic         pin;
  logic         wake_irq = 1'h0;
  psmc_clk_t    clk_ctl;
  psmc_strobe_t strobe_ctl;
  logic         wdt_run;
  logic         slow_mode;
  logic [3:0]   mphase;
  logic [31:0]  rd;
  logic         er;
  int           np;
  int           nc;
  int           nw;
  int           n_fail = 0;
  int           check_count = 0;
  always #12.5 pclk = ~pclk;
  psmc_supervisor psmc_supervisor_inst (.power_fail(power_fail), .save_enable_wdt_start_pin(pin));
  psmc_top #(.DIV(8), .PHASES(12)) psmc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .save_enable_wdt_start_pin(pin), .wake_irq(wake_irq), .clk_ctl(clk_ctl),
    .strobe_ctl(strobe_ctl), .wdt_run(wdt_run), .slow_mode(slow_mode), .machine_phase(mphase));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // the answer is taken at the rising edge that samples pready high, before the
  // slave's registers move on that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic rdy;
    int   n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
      rdy = pready;
    end while (rdy !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk("pready", {31'h0, rdy}, 32'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic st(input string what, input int b, input logic exp);
    apb(1'h0, `PSMC_OFF_STATUS, 32'h0);
    chk(what, {31'h0, rd[b]}, {31'h0, exp});
  endtask
  task automatic rst(input logic fail);
    power_fail <= fail;
    presetn    <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  // the pin is seen once per twelve chip ticks
  task automatic setpin(input logic fail);
    @(posedge pclk);
    power_fail <= fail;
    repeat (16) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic tally(input int n);
    np = 0;
    nc = 0;
    nw = 0;
    repeat (n) begin
      @(negedge pclk);
      np += clk_ctl.periph_en;
      nc += clk_ctl.cpu_en;
      nw += clk_ctl.wdt_en;
    end
  endtask
  task automatic t_autostart;
    rst(1'h0);
    chk("wdt_run", wdt_run, 1);
    chk("phase", mphase, 2);
    st("auto", `PSMC_BIT_ST_AUTO, 1'h1);
    setpin(1'h1);
    chk("wdt_keep", wdt_run, 1);
    st("pin", `PSMC_BIT_ST_PIN, 1'h0);
    $display("test autostart done");
  endtask
  task automatic t_swstart;
    rst(1'h1);
    chk("wdt_off", wdt_run, 0);
    wr(`PSMC_OFF_WDTCTL, 32'h1);
    @(negedge pclk);
    chk("wdt_sw", wdt_run, 1);
    $display("test software start done");
  endtask
  task automatic t_block;
    setpin(1'h0);
    wr(`PSMC_OFF_PCTRL, 32'h01);
    wr(`PSMC_OFF_PCTRL, 32'h20);
    wr(`PSMC_OFF_PCTRL, 32'h02);
    wr(`PSMC_OFF_PCTRL, 32'h40);
    st("blk_sleep", `PSMC_BIT_ST_SLEEP, 1'h0);
    st("blk_halt", `PSMC_BIT_ST_HALT, 1'h0);
    $display("test pin block done");
  endtask
  task automatic t_pairs;
    setpin(1'h1);
    wr(`PSMC_OFF_PCTRL, 32'h21);
    wr(`PSMC_OFF_PCTRL, 32'h20);
    st("both_sleep", `PSMC_BIT_ST_SLEEP, 1'h0);
    wr(`PSMC_OFF_PCTRL, 32'h42);
    wr(`PSMC_OFF_PCTRL, 32'h40);
    st("both_halt", `PSMC_BIT_ST_HALT, 1'h0);
    wr(`PSMC_OFF_PCTRL, 32'h01);
    wr(`PSMC_OFF_WDTCTL, 32'h0);
    wr(`PSMC_OFF_PCTRL, 32'h20);
    st("split", `PSMC_BIT_ST_SLEEP, 1'h0);
    $display("test pairs done");
  endtask
  task automatic t_sleep;
    wr(`PSMC_OFF_PCTRL, 32'h0c);
    wr(`PSMC_OFF_PCTRL, 32'h0d);
    rdchk("arm_read", `PSMC_OFF_PCTRL, 32'h0c);
    wr(`PSMC_OFF_PCTRL, 32'h2c);
    @(negedge pclk);
    chk("ale_high", strobe_ctl.ale_high, 1);
    chk("program_store_strobe_high", strobe_ctl.program_store_strobe_high, 1);
    chk("port_hold", strobe_ctl.port_hold, 1);
    chk("osc", clk_ctl.osc_run, 1);
    tally(16);
    chk("cpu", nc, 0);
    chk("periph", np, 16);
    chk("wdt", nw, 0);
    wr(`PSMC_OFF_PCTRL, 32'h00);
    rdchk("kept", `PSMC_OFF_PCTRL, 32'h0c);
    @(posedge pclk);
    wake_irq <= 1'h1;
    @(posedge pclk);
    wake_irq <= 1'h0;
    @(negedge pclk);
    chk("woken", strobe_ctl.ale_high, 0);
    tally(16);
    chk("cpu_run", nc, 16);
    $display("test sleep done");
  endtask
  task automatic t_slow;
    wr(`PSMC_OFF_PCTRL, 32'h10);
    @(negedge pclk);
    chk("slow", slow_mode, 1);
    tally(80);
    chk("slow_p", np, 10);
    chk("slow_c", nc, 10);
    chk("slow_w", nw, 10);
    wr(`PSMC_OFF_PCTRL, 32'h00);
    tally(8);
    chk("fast_p", np, 8);
    $display("test slow done");
  endtask
  task automatic t_halt;
    wr(`PSMC_OFF_PCTRL, 32'h03);
    wr(`PSMC_OFF_PCTRL, 32'h60);
    @(negedge pclk);
    chk("retain", strobe_ctl.ram_retain, 1);
    chk("osc_off", clk_ctl.osc_run, 0);
    chk("program_store_strobe_low", strobe_ctl.program_store_strobe_low, 1);
    chk("no_sleep", strobe_ctl.ale_high, 0);
    @(posedge pclk);
    wake_irq <= 1'h1;
    tally(16);
    chk("halt_p", np, 0);
    chk("stay", strobe_ctl.ram_retain, 1);
    @(posedge pclk);
    wake_irq <= 1'h0;
    rdchk("unmapped", 12'h00c, 32'h0);
    chk("slverr", er, 1);
    $display("test halt done");
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude;
  end
  initial begin
    t_autostart;
    t_swstart;
    t_block;
    t_pairs;
    t_sleep;
    t_slow;
    t_halt;
    rst(1'h1);
    chk("no_auto", wdt_run, 0);
    st("no_auto_st", `PSMC_BIT_ST_AUTO, 1'h0);
    conclude;
  end
endmodule
`default_nettype wire
